/* File: src/pfc_map.svh */
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH

// Measured values: signed, one LSB is 0.001 unit
`define PFC_VAL_W 32
`define PFC_ZERO 32'h0000_0000

// Step increments 0.001, 0.01, 0.1, 10, 10.0, 100.0
`define PFC_STEP0 32'h0000_0001
`define PFC_STEP1 32'h0000_000A
`define PFC_STEP2 32'h0000_0064
`define PFC_STEP3 32'h0000_2710
`define PFC_STEP4 32'h0000_2710
`define PFC_STEP5 32'h0001_86A0
`define PFC_STEP_MAX_IDX 3'h5
`define PFC_STEP_RST_IDX 3'h2

// Bandwidth in 0.001 percent
`define PFC_BW_MAX 32'h0000_C350
`define PFC_BW_FULL 64'h0000_0000_0001_86A0

// Limit characters on the serial line
`define PFC_CHAR_HIGH 8'h24
`define PFC_CHAR_LOW 8'h22

// Serial timing
`define PFC_CLK_HZ 32'h0EE6_B280
`define PFC_BAUD 32'h0000_2580
`define PFC_BIT_LAST 3'h7

// Reset values
`define PFC_RST_OFF 1'b0
`define PFC_RST_LINE 1'b1

`endif

/* File: src/pfc_pkg.sv */
package pfc_pkg;

  typedef enum logic [2:0] {
    PFC_PAGE_HOME,
    PFC_PAGE_PF,
    PFC_PAGE_VALUE,
    PFC_PAGE_LOAD,
    PFC_PAGE_COMM
  } pfc_page_t;

  typedef enum logic {
    PFC_RANGE,
    PFC_NOMINAL
  } pfc_method_t;

  typedef enum logic [1:0] {
    PFC_TX_IDLE,
    PFC_TX_START,
    PFC_TX_DATA,
    PFC_TX_STOP
  } pfc_tx_state_t;

endpackage

/* File: src/pfc_limit_cmp.sv */
`timescale 1ns/10ps
`include "pfc_map.svh"

module pfc_limit_cmp
  import pfc_pkg::*;
#(
  parameter int W = `PFC_VAL_W
) (
  input wire logic signed [W-1:0] value,
  input wire logic signed [W-1:0] lo_lim,
  input wire logic signed [W-1:0] hi_lim,
  output logic below,
  output logic above
);

  // Strict signed compares; equality counts as inside
  always_comb begin
    below = value < lo_lim;
    above = value > hi_lim;
  end

endmodule // pfc_limit_cmp

/* File: src/pfc_char_tx.sv */
`timescale 1ns/10ps
`include "pfc_map.svh"

module pfc_char_tx
  import pfc_pkg::*;
#(
  parameter int BAUD_DIV = `PFC_CLK_HZ / `PFC_BAUD
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  output logic char_ready,
  output logic txd
);

  pfc_tx_state_t state_reg;
  logic [31:0] baud_cnt_reg;
  logic [2:0] bit_idx_reg;
  logic [7:0] shift_reg;
  logic baud_tick;

  assign baud_tick = baud_cnt_reg == 32'(BAUD_DIV - 1);
  assign char_ready = state_reg == PFC_TX_IDLE;

  // Bit timer
  always_ff @(posedge clk) begin
    if (!rstn || state_reg == PFC_TX_IDLE || baud_tick) begin
      baud_cnt_reg <= `PFC_ZERO;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 32'h0000_0001;
    end
  end

  // Frame sequencer: start, eight data bits LSB first, stop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= PFC_TX_IDLE;
      bit_idx_reg <= 3'h0;
      shift_reg <= 8'h00;
      txd <= `PFC_RST_LINE;
    end else begin
      case (state_reg)
        PFC_TX_IDLE: begin
          txd <= `PFC_RST_LINE;
          if (char_valid) begin
            shift_reg <= char_data;
            state_reg <= PFC_TX_START;
            txd <= 1'b0;
          end
        end
        PFC_TX_START: begin
          if (baud_tick) begin
            state_reg <= PFC_TX_DATA;
            bit_idx_reg <= 3'h0;
            txd <= shift_reg[0];
          end
        end
        PFC_TX_DATA: begin
          if (baud_tick) begin
            if (bit_idx_reg == `PFC_BIT_LAST) begin
              state_reg <= PFC_TX_STOP;
              txd <= 1'b1;
            end else begin
              bit_idx_reg <= bit_idx_reg + 3'h1;
              txd <= shift_reg[bit_idx_reg + 3'h1];
            end
          end
        end
        PFC_TX_STOP: begin
          if (baud_tick) begin
            state_reg <= PFC_TX_IDLE;
          end
        end
        default: begin
          state_reg <= PFC_TX_IDLE;
          txd <= `PFC_RST_LINE;
        end
      endcase
    end
  end

endmodule // pfc_char_tx

/* File: src/pfc_top.sv */
// Functional notes
// RULE1: Range method: pass when low limit <= value <= high limit.
// RULE2: Range method: fail when value above high or below low limit.
// RULE3: Nominal method: limits are nominal plus/minus bandwidth percent of nominal.
// RULE4: Nominal method: pass inside derived limits inclusive, fail outside.
// RULE5: Derived limits recompute whenever nominal or bandwidth changes.
// RULE6: Bandwidth never exceeds fifty percent.
// RULE7: Pass/fail enable resets off and can be toggled.
// RULE8: Method selects exactly one of range or nominal.
// RULE9: Six step sizes; right key larger, left key smaller; the code has 10.0 as both the fourth and fifth step.
// RULE10: Up/down changes the edited value by exactly one step.
// RULE11: Soft key toggles edited value; nominal editing starts on nominal.
// RULE12: Low-load tag set below low setpoint, cleared once above it.
// RULE13: High-load tag set above high setpoint, cleared once below it.
// RULE14: Buzzer enabled: alarm sounds at a load limit, icon shows.
// RULE15: Soft key switches the buzzer setting.
// RULE16: Limit transmit resets off; right key enables, left disables.
// RULE17: Transmit on and high limit: dollar characters repeat on serial line.
// RULE18: Transmit on and low limit: distinct low character repeats on serial line.
// RULE19: Verdict only for peak-mode or saved results.
// RULE20: No verdict for normal-mode results.
// RULE21: All compares signed, same fixed-point scale as measured value.
`timescale 1ns/10ps
`include "pfc_map.svh"

module pfc_top
  import pfc_pkg::*;
#(
  parameter int BAUD_DIV = `PFC_CLK_HZ / `PFC_BAUD
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic signed [31:0] meas_value,
  input wire logic meas_valid,
  input wire logic tension_peak_mode,
  input wire logic compression_peak_mode,
  input wire logic result_saved,
  input wire pfc_page_t setup_page,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_left,
  input wire logic key_right,
  input wire logic soft_key_one,
  input wire logic soft_key_two,
  output logic pf_pass,
  output logic pf_fail,
  output logic signed [31:0] shown_high_limit,
  output logic signed [31:0] shown_low_limit,
  output logic low_load_alarm_tag,
  output logic high_load_alarm_tag,
  output logic buzzer_sound,
  output logic buzzer_icon,
  output logic txd
);

  logic pf_en_reg, xmit_en_reg, field_reg, load_field_reg;
  pfc_method_t method_reg;
  logic [2:0] step_idx_reg;
  pfc_page_t page_reg;
  logic signed [31:0] range_high_reg, range_low_reg, nom_reg, bw_reg;
  logic signed [31:0] load_high_reg, load_low_reg, step_val, adj_next, bw_next;
  logic [31:0] nom_abs;
  logic [63:0] nom_prod;
  logic signed [31:0] nom_delta, der_high_calc, der_low_calc, act_high, act_low;
  logic pf_below, pf_above, ld_below, ld_above, eval_now, normal_now;
  logic value_page, load_page, tx_valid, tx_ready;
  logic [7:0] tx_char;

  assign value_page = setup_page == PFC_PAGE_VALUE;
  assign load_page = setup_page == PFC_PAGE_LOAD;

  // Step size lookup
  always_comb begin
    case (step_idx_reg)
      3'h0: step_val = `PFC_STEP0;
      3'h1: step_val = `PFC_STEP1;
      3'h2: step_val = `PFC_STEP2;
      3'h3: step_val = `PFC_STEP3;
      3'h4: step_val = `PFC_STEP4;
      3'h5: step_val = `PFC_STEP5;
      default: step_val = `PFC_STEP0;
    endcase
  end

  // Step selection on value and load pages
  always_ff @(posedge clk) begin
    if (!rstn) begin
      step_idx_reg <= `PFC_STEP_RST_IDX;
    end else if (value_page || load_page) begin
      if (key_right && step_idx_reg != `PFC_STEP_MAX_IDX) begin
        step_idx_reg <= step_idx_reg + 3'h1; // [RULE9]
      end else if (key_left && step_idx_reg != 3'h0) begin
        step_idx_reg <= step_idx_reg - 3'h1; // [RULE9]
      end
    end
  end

  // Enable and method
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pf_en_reg <= `PFC_RST_OFF;
      method_reg <= PFC_RANGE;
    end else if (setup_page == PFC_PAGE_PF) begin
      if (soft_key_one) begin
        pf_en_reg <= !pf_en_reg; // [RULE7]
      end
      if (key_up) begin
        method_reg <= PFC_RANGE; // [RULE8]
      end else if (key_down) begin
        method_reg <= PFC_NOMINAL; // [RULE8]
      end
    end
  end

  // Edited fields; value field returns to high or nominal on entering its page, load field does not
  always_ff @(posedge clk) begin
    if (!rstn) begin
      page_reg <= PFC_PAGE_HOME;
      field_reg <= 1'b0;
      load_field_reg <= 1'b0;
    end else begin
      page_reg <= setup_page;
      if (value_page && page_reg != PFC_PAGE_VALUE) begin
        field_reg <= 1'b0; // [RULE11]
      end else if (value_page && soft_key_one) begin
        field_reg <= !field_reg; // [RULE11]
      end
      if (load_page && soft_key_one) begin
        load_field_reg <= !load_field_reg;
      end
    end
  end

  // Value of the edited field after one key press
  always_comb begin
    case ({load_page, field_reg, method_reg == PFC_NOMINAL})
      3'b000: adj_next = range_high_reg;
      3'b010: adj_next = range_low_reg;
      3'b001: adj_next = nom_reg;
      3'b011: adj_next = bw_reg;
      default: adj_next = load_field_reg ? load_low_reg : load_high_reg;
    endcase
    if (key_up) begin
      adj_next = adj_next + step_val; // [RULE10]
    end else if (key_down) begin
      adj_next = adj_next - step_val; // [RULE10]
    end
    bw_next = adj_next;
    if (adj_next > signed'(`PFC_BW_MAX)) begin
      bw_next = `PFC_BW_MAX; // [RULE6]
    end else if (adj_next < signed'(`PFC_ZERO)) begin
      bw_next = `PFC_ZERO;
    end
  end

  // Setpoint storage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      range_high_reg <= `PFC_ZERO;
      range_low_reg <= `PFC_ZERO;
      nom_reg <= `PFC_ZERO;
      bw_reg <= `PFC_ZERO;
      load_high_reg <= `PFC_ZERO;
      load_low_reg <= `PFC_ZERO;
    end else if (key_up || key_down) begin
      if (value_page && method_reg == PFC_RANGE) begin
        if (field_reg) begin
          range_low_reg <= adj_next; // [RULE10]
        end else begin
          range_high_reg <= adj_next; // [RULE10]
        end
      end else if (value_page) begin
        if (field_reg) begin
          bw_reg <= bw_next; // [RULE6]
        end else begin
          nom_reg <= adj_next;
        end
      end else if (load_page) begin
        if (load_field_reg) begin
          load_low_reg <= adj_next;
        end else begin
          load_high_reg <= adj_next;
        end
      end
    end
  end

  // Derived limits, recomputed every cycle from the stored values
  always_comb begin
    nom_abs = nom_reg < signed'(`PFC_ZERO) ? 32'(-nom_reg) : 32'(nom_reg); // [RULE21]
    nom_prod = (64'(nom_abs) * 64'(bw_reg)) / `PFC_BW_FULL;
    nom_delta = signed'(nom_prod[31:0]);
    der_high_calc = nom_reg + nom_delta; // [RULE3]
    der_low_calc = nom_reg - nom_delta; // [RULE3]
    act_high = method_reg == PFC_NOMINAL ? der_high_calc : range_high_reg;
    act_low = method_reg == PFC_NOMINAL ? der_low_calc : range_low_reg;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      shown_high_limit <= `PFC_ZERO;
      shown_low_limit <= `PFC_ZERO;
    end else begin
      shown_high_limit <= act_high; // [RULE5]
      shown_low_limit <= act_low; // [RULE5]
    end
  end

  pfc_limit_cmp #(.W(`PFC_VAL_W)) u_pf_cmp (
    .value(meas_value),
    .lo_lim(act_low),
    .hi_lim(act_high),
    .below(pf_below),
    .above(pf_above)
  ); // [RULE21]

  pfc_limit_cmp #(.W(`PFC_VAL_W)) u_load_cmp (
    .value(meas_value),
    .lo_lim(load_low_reg),
    .hi_lim(load_high_reg),
    .below(ld_below),
    .above(ld_above)
  ); // [RULE21]

  assign eval_now = meas_valid && pf_en_reg &&
                    (tension_peak_mode || compression_peak_mode || result_saved);
  assign normal_now = meas_valid && !tension_peak_mode && !compression_peak_mode &&
                      !result_saved;

  // Verdict
  always_ff @(posedge clk) begin
    if (!rstn || !pf_en_reg || normal_now) begin
      pf_pass <= 1'b0; // [RULE20]
      pf_fail <= 1'b0; // [RULE20]
    end else if (eval_now) begin
      pf_pass <= !pf_below && !pf_above; // [RULE1] [RULE4] [RULE19]
      pf_fail <= pf_below || pf_above; // [RULE2] [RULE4] [RULE19]
    end
  end

  // Load tags with hold on equality
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_load_alarm_tag <= 1'b0;
      high_load_alarm_tag <= 1'b0;
    end else if (meas_valid) begin
      if (ld_below) begin
        low_load_alarm_tag <= 1'b1; // [RULE12]
      end else if (meas_value > load_low_reg) begin
        low_load_alarm_tag <= 1'b0; // [RULE12]
      end
      if (ld_above) begin
        high_load_alarm_tag <= 1'b1; // [RULE13]
      end else if (meas_value < load_high_reg) begin
        high_load_alarm_tag <= 1'b0; // [RULE13]
      end
    end
  end

  // Buzzer and transmit settings
  always_ff @(posedge clk) begin
    if (!rstn) begin
      buzzer_icon <= `PFC_RST_OFF;
      xmit_en_reg <= `PFC_RST_OFF;
    end else begin
      if (soft_key_two) begin
        buzzer_icon <= !buzzer_icon; // [RULE15] [RULE14]
      end
      if (setup_page == PFC_PAGE_COMM && key_right) begin
        xmit_en_reg <= 1'b1; // [RULE16]
      end else if (setup_page == PFC_PAGE_COMM && key_left) begin
        xmit_en_reg <= 1'b0; // [RULE16]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      buzzer_sound <= 1'b0;
    end else begin
      buzzer_sound <= buzzer_icon && (low_load_alarm_tag || high_load_alarm_tag); // [RULE14]
    end
  end

  // Limit characters repeat while a tag stands; high wins
  assign tx_valid = xmit_en_reg && (high_load_alarm_tag || low_load_alarm_tag);
  assign tx_char = high_load_alarm_tag ? `PFC_CHAR_HIGH : `PFC_CHAR_LOW; // [RULE17] [RULE18]

  pfc_char_tx #(.BAUD_DIV(BAUD_DIV)) u_tx (
    .clk(clk),
    .rstn(rstn),
    .char_valid(tx_valid),
    .char_data(tx_char),
    .char_ready(tx_ready),
    .txd(txd)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  range_pass_a: assert property ( // [RULE1]
    (eval_now && method_reg == PFC_RANGE && meas_value >= range_low_reg &&
     meas_value <= range_high_reg) |=> pf_pass && !pf_fail)
    else $error("range pass wrong");
  range_fail_a: assert property ( // [RULE2]
    (eval_now && method_reg == PFC_RANGE && meas_value > range_high_reg) |=> pf_fail && !pf_pass)
    else $error("range fail wrong");
  nom_limits_a: assert property ( // [RULE3] [RULE5]
    method_reg == PFC_NOMINAL |=> shown_high_limit == $past(nom_reg) + $past(nom_delta) &&
      shown_low_limit == $past(nom_reg) - $past(nom_delta))
    else $error("derived limits wrong");
  nom_verdict_a: assert property ( // [RULE4]
    (eval_now && method_reg == PFC_NOMINAL && meas_value < der_low_calc) |=> pf_fail)
    else $error("nominal verdict wrong");
  bw_cap_a: assert property (bw_reg <= signed'(`PFC_BW_MAX) && !bw_reg[31]) // [RULE6]
    else $error("bandwidth above cap");
  pf_off_a: assert property (!pf_en_reg |=> !pf_pass && !pf_fail) // [RULE7]
    else $error("verdict while disabled");
  normal_mode_a: assert property (normal_now |=> !pf_pass && !pf_fail) // [RULE20]
    else $error("verdict in normal mode");
  step_up_a: assert property ( // [RULE10]
    (value_page && method_reg == PFC_RANGE && !field_reg && key_up) |=>
      range_high_reg == $past(range_high_reg) + $past(step_val))
    else $error("step adjust wrong");
  low_tag_a: assert property ((meas_valid && ld_below) |=> low_load_alarm_tag) // [RULE12]
    else $error("low tag missing");
  high_tag_a: assert property ( // [RULE13]
    (meas_valid && meas_value < load_high_reg) |=> !high_load_alarm_tag)
    else $error("high tag not cleared");
  buzzer_a: assert property ( // [RULE14]
    (buzzer_icon && high_load_alarm_tag) |=> buzzer_sound)
    else $error("buzzer silent");
  xmit_high_a: assert property ( // [RULE17]
    (tx_valid && tx_ready && high_load_alarm_tag) |-> tx_char == `PFC_CHAR_HIGH ##1 !txd)
    else $error("high char not sent");
  range_pass_c: cover property (eval_now && method_reg == PFC_RANGE ##1 pf_pass);
  nom_fail_c: cover property (eval_now && method_reg == PFC_NOMINAL ##1 pf_fail);
  xmit_low_c: cover property (tx_valid && tx_ready && !high_load_alarm_tag);

endmodule // pfc_top

/* File: verification/pfc_stand_model.sv */
`timescale 1ns/10ps

module pfc_stand_model #(
  parameter int BAUD_DIV = 4
) (
  input wire logic clk,
  input wire logic txd,
  output logic [7:0] rx_char,
  output int rx_count,
  output int frame_err,
  output logic stop_motion
);
  logic [7:0] sh;

  // Bits sampled mid-cell on the falling clock
  initial begin
    rx_char = 8'h00;
    rx_count = 0;
    frame_err = 0;
    stop_motion = 1'b0;
    forever begin
      @(negedge txd);
      repeat (BAUD_DIV / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_DIV) @(negedge clk);
        sh[i] = txd;
      end
      repeat (BAUD_DIV) @(negedge clk);
      if (txd !== 1'b1) begin
        frame_err++;
      end
      rx_char = sh;
      rx_count++;
      // Crosshead halts on either limit character
      if (sh == 8'h24 || sh == 8'h22) begin
        stop_motion = 1'b1;
      end
    end
  end
endmodule // pfc_stand_model

/* File: verification/tb_pfc_top.sv */
`timescale 1ns/10ps
`include "pfc_map.svh"

module tb_pfc_top
  import pfc_pkg::*;
  ;
  localparam int UP = 0, DN = 1, LF = 2, RT = 3, S1 = 4, S2 = 5;
  logic clk, rstn, meas_valid;
  logic signed [31:0] meas_value;
  logic [2:0] mode; // Saved, compression, tension
  pfc_page_t page;
  logic [5:0] keys;
  logic pf_pass, pf_fail, lo_tag, hi_tag, buz, icon, txd, stop_motion;
  logic signed [31:0] hi_lim, lo_lim;
  logic [7:0] rx_char;
  int rx_count, frame_err, bad_count, check_count, cycles, rec;
  int lv[6] = '{10001, 10000, 9999, -10001, -10000, -9999};
  logic [1:0] lt[6] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h0};

  pfc_top #(.BAUD_DIV(4)) dut_u (
    .clk(clk), .rstn(rstn), .meas_value(meas_value), .meas_valid(meas_valid),
    .tension_peak_mode(mode[0]), .compression_peak_mode(mode[1]),
    .result_saved(mode[2]), .setup_page(page),
    .key_up(keys[UP]), .key_down(keys[DN]), .key_left(keys[LF]), .key_right(keys[RT]),
    .soft_key_one(keys[S1]), .soft_key_two(keys[S2]),
    .pf_pass(pf_pass), .pf_fail(pf_fail),
    .shown_high_limit(hi_lim), .shown_low_limit(lo_lim),
    .low_load_alarm_tag(lo_tag), .high_load_alarm_tag(hi_tag),
    .buzzer_sound(buz), .buzzer_icon(icon), .txd(txd)
  );

  pfc_stand_model #(.BAUD_DIV(4)) stand_u (
    .clk(clk), .txd(txd), .rx_char(rx_char), .rx_count(rx_count),
    .frame_err(frame_err), .stop_motion(stop_motion)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic results();
    $display("Counts: %0d checks, %0d mismatches", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic press(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      keys <= 6'h01 << k;
      @(posedge clk);
      keys <= 6'h00;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic meas(input int v, input logic [2:0] m);
    @(posedge clk);
    meas_value <= v;
    meas_valid <= 1'b1;
    mode <= m;
    @(posedge clk);
    meas_valid <= 1'b0;
    #1;
  endtask

  task automatic go(input pfc_page_t p);
    @(posedge clk);
    page <= p;
  endtask

  task automatic vchk(input int v, input logic [2:0] m, input logic ep, input logic ef);
    meas(v, m);
    chk(pf_pass, ep, "pass");
    chk(pf_fail, ef, "fail");
  endtask

  task automatic limchk(input int h, input int l);
    chk(hi_lim, h, "high limit");
    chk(lo_lim, l, "low limit");
  endtask

  task automatic wait_rx(input int n);
    int c0;
    c0 = rx_count;
    for (int i = 0; i < 500 && rx_count < c0 + n; i++) @(posedge clk);
    chk(rx_count >= c0 + n, 1, "frames seen");
  endtask

  initial begin
    rstn = 1'b0;
    meas_value = 0;
    meas_valid = 1'b0;
    mode = 3'h0;
    page = PFC_PAGE_HOME;
    keys = 6'h00;
    bad_count = 0;
    check_count = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk({pf_pass, pf_fail, lo_tag, hi_tag, buz, icon, txd}, 7'h01, "reset outs");
    limchk(0, 0);
    $display("Test reset done");
    go(PFC_PAGE_VALUE);
    press(UP, 3);
    limchk(300, 0);
    press(RT, 1);
    press(UP, 1);
    limchk(10300, 0);
    press(LF, 2);
    press(S1, 1);
    press(DN, 2);
    limchk(10300, -20);
    press(LF, 3);
    press(UP, 1);
    limchk(10300, -19);
    press(RT, 7);
    press(DN, 1);
    limchk(10300, -100019);
    $display("Test range setup done");
    vchk(0, 3'h1, 1'b0, 1'b0);
    go(PFC_PAGE_PF);
    press(S1, 1);
    vchk(10300, 3'h1, 1'b1, 1'b0);
    vchk(10301, 3'h1, 1'b0, 1'b1);
    vchk(-100019, 3'h2, 1'b1, 1'b0);
    vchk(-100020, 3'h2, 1'b0, 1'b1);
    vchk(0, 3'h4, 1'b1, 1'b0);
    vchk(0, 3'h0, 1'b0, 1'b0);
    $display("Test range verdict done");
    press(DN, 1);
    go(PFC_PAGE_VALUE);
    press(UP, 1);
    limchk(100000, 100000);
    press(S1, 1);
    press(LF, 2);
    press(UP, 1);
    limchk(110000, 90000);
    vchk(110000, 3'h1, 1'b1, 1'b0);
    vchk(110001, 3'h1, 1'b0, 1'b1);
    vchk(90000, 3'h1, 1'b1, 1'b0);
    vchk(89999, 3'h1, 1'b0, 1'b1);
    press(UP, 5);
    limchk(150000, 50000);
    press(S1, 1);
    press(DN, 1);
    limchk(135000, 45000);
    press(RT, 2);
    press(DN, 2);
    limchk(-55000, -165000);
    press(S1, 1);
    press(LF, 2);
    press(DN, 6);
    limchk(-110000, -110000);
    vchk(-110001, 3'h2, 1'b0, 1'b1);
    $display("Test nominal done");
    go(PFC_PAGE_LOAD);
    press(UP, 1);
    press(S1, 1);
    press(DN, 1);
    press(S2, 1);
    chk(icon, 1, "icon on");
    for (int i = 0; i < 6; i++) begin
      meas(lv[i], 3'h0);
      chk({hi_tag, lo_tag}, lt[i], "load tags");
      @(posedge clk);
      #1;
      chk(buz, |lt[i], "buzzer");
    end
    press(S2, 1);
    chk(icon, 0, "icon off");
    meas(20000, 3'h0);
    @(posedge clk);
    #1;
    chk(buz, 0, "buzzer muted");
    $display("Test load limits done");
    chk(rx_count, 0, "line quiet");
    go(PFC_PAGE_COMM);
    press(RT, 1);
    wait_rx(2);
    chk(rx_char, `PFC_CHAR_HIGH, "high char");
    chk(stop_motion, 1, "stand halted");
    meas(-20000, 3'h0);
    wait_rx(3);
    chk(rx_char, `PFC_CHAR_LOW, "low char");
    press(LF, 1);
    meas(0, 3'h0);
    repeat (60) @(posedge clk);
    rec = rx_count;
    repeat (100) @(posedge clk);
    #1;
    chk(rx_count, rec, "no frames");
    chk(txd, 1, "idle line");
    chk(frame_err, 0, "framing");
    $display("Test serial done");
    results();
  end
endmodule // tb_pfc_top
